// [rtl/bfp_core.sv]
// breaker failure pick-up, blocking and retrip/failure timing with AHB-Lite settings
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module bfp_core #(
    parameter int unsigned TICK_CYCLES = bfp_pkg::TICK_CYCLES,
    parameter int unsigned MEAS_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic meas_valid,
    input wire logic [MEAS_W-1:0] phase_a_rms,
    input wire logic [MEAS_W-1:0] phase_b_rms,
    input wire logic [MEAS_W-1:0] phase_c_rms,
    input wire logic [MEAS_W-1:0] residual_input_one,
    input wire logic [MEAS_W-1:0] residual_input_two,
    input wire logic [MEAS_W-1:0] derived_residual_current,
    input wire logic binary_signal,
    input wire logic relay_state,
    input wire logic block_request,
    output logic start,
    output logic retrip,
    output logic breaker_failure_output,
    output logic blocked,
    output logic block_event,
    output logic [3:0] event_fault_type,
    output logic [MEAS_W-1:0] event_cur_a,
    output logic [MEAS_W-1:0] event_cur_b,
    output logic [MEAS_W-1:0] event_cur_c,
    output logic [MEAS_W-1:0] event_cur_n
);
    import bfp_pkg::*;

    if (TICK_CYCLES < 1 || TICK_CYCLES > 16777215) begin : g_bad_tick
        $error("bfp_core: TICK_CYCLES out of range");
    end
    if (MEAS_W != 16) begin : g_bad_meas
        $error("bfp_core: MEAS_W must be 16");
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave and settings

    logic [3:0] mode_r;
    logic [1:0] rsel_r;
    logic rten_r;
    logic [2:0] ln_r;
    logic [11:0] phase_thr_r;
    logic [15:0] res_thr_r;
    logic [18:0] retrip_dly_r;
    logic [18:0] fail_dly_r;
    logic wr_pend_r;
    logic rd_pend_r;
    logic rd_done_r;
    logic [7:0] addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_word;
    logic accept;
    bfp_state_t state_r;
    bfp_state_t state_nxt;
    logic [18:0] elapsed_r;
    logic [18:0] elapsed_nxt;
    logic [3:0] ch_pick_r;
    logic pickup;
    logic [2:0] cond;
    logic [2:0] behaviour;

    // reads take one wait state so a write just before is already visible
    assign hreadyout = clk_en & ~(rd_pend_r & ~rd_done_r);
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign accept = clk_en & hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            rd_done_r <= 1'b0;
            addr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end else if (clk_en) begin
            if (rd_pend_r && !rd_done_r) begin
                hrdata_r <= rd_word;
                rd_done_r <= 1'b1;
            end else begin
                wr_pend_r <= accept & hwrite;
                rd_pend_r <= accept & ~hwrite;
                rd_done_r <= 1'b0;
                if (accept) begin
                    addr_r <= {haddr[7:2], 2'b00};
                end
            end
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        if (addr_r == OFS_CTRL) begin
            rd_word[CTRL_MODE_LSB +: 4] = mode_r;
            rd_word[CTRL_RSEL_LSB +: 2] = rsel_r;
            rd_word[CTRL_RTEN_BIT] = rten_r;
            rd_word[CTRL_LN_LSB +: 3] = ln_r;
        end else if (addr_r == OFS_PHASE_THR) begin
            rd_word[11:0] = phase_thr_r;
        end else if (addr_r == OFS_RES_THR) begin
            rd_word[15:0] = res_thr_r;
        end else if (addr_r == OFS_RETRIP_DLY) begin
            rd_word[18:0] = retrip_dly_r;
        end else if (addr_r == OFS_FAIL_DLY) begin
            rd_word[18:0] = fail_dly_r;
        end else if (addr_r == OFS_STATUS) begin
            rd_word[STAT_COND_LSB +: 3] = cond;
            rd_word[STAT_BEH_LSB +: 3] = behaviour;
            rd_word[STAT_CH_LSB +: 4] = ch_pick_r;
            rd_word[STAT_PICK_BIT] = pickup;
        end else if (addr_r == OFS_ELAPSED) begin
            rd_word[18:0] = elapsed_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= RST_MODE;
            rsel_r <= RST_RSEL;
            rten_r <= RST_RTEN;
            ln_r <= RST_LN;
            phase_thr_r <= RST_PHASE_THR;
            res_thr_r <= RST_RES_THR;
            retrip_dly_r <= RST_RETRIP_STEPS;
            fail_dly_r <= RST_FAIL_STEPS;
        end else if (clk_en && wr_pend_r) begin
            if (addr_r == OFS_CTRL) begin
                mode_r <= hwdata[CTRL_MODE_LSB +: 4];
                rsel_r <= hwdata[CTRL_RSEL_LSB +: 2];
                rten_r <= hwdata[CTRL_RTEN_BIT];
                ln_r <= hwdata[CTRL_LN_LSB +: 3];
            end else if (addr_r == OFS_PHASE_THR) begin
                phase_thr_r <= hwdata[11:0];
            end else if (addr_r == OFS_RES_THR) begin
                res_thr_r <= hwdata[15:0];
            end else if (addr_r == OFS_RETRIP_DLY) begin
                retrip_dly_r <= (hwdata[18:0] > DLY_MAX) ? DLY_MAX : hwdata[18:0];
            end else if (addr_r == OFS_FAIL_DLY) begin
                fail_dly_r <= (hwdata[18:0] > DLY_MAX) ? DLY_MAX : hwdata[18:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // measurement latch and current comparators, one per channel

    logic [15:0] res_sel;
    logic [15:0] meas_in [4];
    logic [16:0] thr_lvl [4];

    always_comb begin
        case (rsel_r)
            RSEL_ONE: res_sel = residual_input_one;
            RSEL_TWO: res_sel = residual_input_two;
            RSEL_CALC: res_sel = derived_residual_current;
            default: res_sel = 16'h0000;
        endcase
    end

    assign meas_in[0] = phase_a_rms;
    assign meas_in[1] = phase_b_rms;
    assign meas_in[2] = phase_c_rms;
    assign meas_in[3] = res_sel;
    // phase threshold in 0.01 steps brought to the 0.001 scale of the inputs
    assign thr_lvl[0] = 17'(phase_thr_r) * PHASE_SCALE;
    assign thr_lvl[1] = 17'(phase_thr_r) * PHASE_SCALE;
    assign thr_lvl[2] = 17'(phase_thr_r) * PHASE_SCALE;
    assign thr_lvl[3] = 17'(res_thr_r);

    for (genvar ch = 0; ch < 4; ch++) begin : g_ch
        logic [15:0] meas_r;
        logic above;
        logic below_drop;
        logic en;
        assign en = (ch < 3) || (rsel_r != RSEL_OFF);
        assign above = 17'(meas_r) > thr_lvl[ch];
        assign below_drop = (24'(meas_r) * HYST_DEN) < (24'(thr_lvl[ch]) * HYST_NUM);

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                meas_r <= 16'h0000;
            end else if (clk_en && meas_valid) begin
                meas_r <= meas_in[ch];
            end
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ch_pick_r[ch] <= 1'b0;
            end else if (clk_en) begin
                if (!en) begin
                    ch_pick_r[ch] <= 1'b0;
                end else if (!ch_pick_r[ch]) begin
                    ch_pick_r[ch] <= above;
                end else begin
                    ch_pick_r[ch] <= ~below_drop;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode combination, blocking and sequencing

    logic cur_pick;
    logic block_eff;
    logic ln_off;
    logic tick;
    logic [23:0] presc_r;

    assign cur_pick = |ch_pick_r;
    assign ln_off = (ln_r == LN_OFF);
    // block is looked at every cycle, never remembered from an earlier one
    assign block_eff = block_request | (ln_r == LN_BLOCKED) | (ln_r == LN_TEST_BLOCKED);

    always_comb begin
        case (mode_r)
            MODE_CUR: pickup = cur_pick;
            MODE_RELAY: pickup = relay_state;
            MODE_SIG: pickup = binary_signal;
            MODE_CUR_AND_RELAY: pickup = cur_pick & relay_state;
            MODE_CUR_OR_RELAY: pickup = cur_pick | relay_state;
            MODE_CUR_OR_SIG: pickup = cur_pick | binary_signal;
            MODE_CUR_OR_SIG_RELAY: pickup = cur_pick | (binary_signal & relay_state);
            MODE_SIG_OR_RELAY: pickup = binary_signal | relay_state;
            MODE_ANY: pickup = cur_pick | relay_state | binary_signal;
            MODE_ALL: pickup = cur_pick & relay_state & binary_signal;
            default: pickup = 1'b0;
        endcase
        if (ln_off) begin
            pickup = 1'b0;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_NORMAL: begin
                if (pickup) begin
                    state_nxt = block_eff ? ST_BLOCKED : ST_START;
                end
            end
            ST_START: begin
                if (!pickup) begin
                    state_nxt = ST_NORMAL;
                end else if (block_eff) begin
                    state_nxt = ST_BLOCKED;
                end
            end
            ST_BLOCKED: begin
                if (!pickup) begin
                    state_nxt = ST_NORMAL;
                end else if (!block_eff) begin
                    state_nxt = ST_START;
                end
            end
            default: state_nxt = ST_NORMAL;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_NORMAL;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared 5 ms tick timer for retrip and failure

    assign tick = (presc_r == 24'(TICK_CYCLES - 1));

    always_comb begin
        elapsed_nxt = elapsed_r;
        if (state_r != ST_START || state_nxt != ST_START) begin
            elapsed_nxt = 19'h00000;
        end else if (tick && elapsed_r < DLY_MAX) begin
            elapsed_nxt = elapsed_r + 19'h00001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_r <= 24'h000000;
            elapsed_r <= 19'h00000;
        end else if (clk_en) begin
            elapsed_r <= elapsed_nxt;
            if (state_r != ST_START || state_nxt != ST_START || tick) begin
                presc_r <= 24'h000000;
            end else begin
                presc_r <= presc_r + 24'h000001;
            end
        end
    end

    // outputs follow the next state so they drop in the same edge as start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start <= 1'b0;
            retrip <= 1'b0;
            breaker_failure_output <= 1'b0;
            blocked <= 1'b0;
        end else if (clk_en) begin
            start <= (state_nxt == ST_START);
            retrip <= (state_nxt == ST_START) & rten_r & (elapsed_nxt >= retrip_dly_r);
            breaker_failure_output <= (state_nxt == ST_START) & (elapsed_nxt >= fail_dly_r);
            blocked <= (state_nxt == ST_BLOCKED);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // block event capture

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            block_event <= 1'b0;
            event_fault_type <= 4'h0;
            event_cur_a <= 16'h0000;
            event_cur_b <= 16'h0000;
            event_cur_c <= 16'h0000;
            event_cur_n <= 16'h0000;
        end else if (clk_en) begin
            block_event <= (state_nxt == ST_BLOCKED) && (state_r != ST_BLOCKED);
            if (state_nxt == ST_BLOCKED && state_r != ST_BLOCKED) begin
                event_fault_type <= ch_pick_r;
                event_cur_a <= g_ch[0].meas_r;
                event_cur_b <= g_ch[1].meas_r;
                event_cur_c <= g_ch[2].meas_r;
                event_cur_n <= g_ch[3].meas_r;
            end
        end
    end

    always_comb begin
        if (breaker_failure_output) begin
            cond = COND_FAIL;
        end else if (retrip) begin
            cond = COND_RETRIP;
        end else if (start) begin
            cond = COND_START;
        end else if (blocked) begin
            cond = COND_BLOCKED;
        end else begin
            cond = COND_NORMAL;
        end
        behaviour = (ln_r >= LN_ON && ln_r <= LN_OFF) ? ln_r : LN_OFF;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_PICK_SET: assert property (clk_en && !ch_pick_r[0] && g_ch[0].above |=> ch_pick_r[0])
        else $error("phase a above threshold did not pick");
    AST_HYST_HOLD: assert property (clk_en && ch_pick_r[0] && !g_ch[0].below_drop
        |=> ch_pick_r[0])
        else $error("phase a dropped above 97 percent");
    AST_RES_OFF: assert property (clk_en && rsel_r == RSEL_OFF |=> !ch_pick_r[3])
        else $error("residual picked while source off");
    AST_MODE_BAD: assert property (mode_r == 4'h7 || mode_r > 4'hA |-> !pickup)
        else $error("invalid mode produced pick-up");
    AST_SIG_DIRECT: assert property (mode_r == MODE_SIG && !ln_off |-> pickup == binary_signal)
        else $error("signal criterion delayed");
    AST_START_CLEAN: assert property ($rose(start) |-> $past(!block_eff && pickup))
        else $error("start without clean pick-up");
    AST_BLOCK_CLEAR: assert property (clk_en && start && block_eff && pickup
        |=> blocked && !start && !retrip && !breaker_failure_output && elapsed_r == 19'h00000)
        else $error("block did not clear start");
    AST_RELEASE: assert property (clk_en && start && !pickup
        |=> !start && !retrip && !breaker_failure_output && elapsed_r == 19'h00000)
        else $error("release did not reset timers");
    AST_NO_RETRIP: assert property (retrip |-> $past(rten_r))
        else $error("retrip while disabled");
    AST_FAIL_TIME: assert property (breaker_failure_output |-> start && elapsed_r >= fail_dly_r)
        else $error("failure output early");
    AST_RETRIP_TIME: assert property (clk_en && start && rten_r && pickup && !block_eff
        && elapsed_nxt >= retrip_dly_r |=> retrip)
        else $error("retrip late");
    AST_BLOCK_EVT: assert property (block_event |-> blocked && !start && elapsed_r == 19'h00000)
        else $error("block event without blocked state");
    AST_COND: assert property (breaker_failure_output |-> cond == COND_FAIL)
        else $error("condition code wrong");

    COV_RETRIP: cover property ($rose(retrip));
    COV_FAIL: cover property ($rose(breaker_failure_output));
    COV_BLOCK_START: cover property (start ##1 blocked);
    COV_RELEASE: cover property (start ##1 !start && !blocked);
endmodule

// [rtl/bfp_pkg.sv]
// constants, codes and register map of the breaker failure pick-up timer
package bfp_pkg;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned TICK_TIME_MS = 5;
    localparam int unsigned TICK_CYCLES = (TICK_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned DELAY_STEP_MS = 5;
    localparam int unsigned MAX_DELAY_MS = 1800000;
    localparam int unsigned MAX_DELAY_STEPS = MAX_DELAY_MS / DELAY_STEP_MS;
    localparam int unsigned RETRIP_DELAY_MS = 100;
    localparam int unsigned FAIL_DELAY_MS = 200;
    localparam int unsigned DLY_W = 19;
    localparam logic [18:0] RST_RETRIP_STEPS = 19'(RETRIP_DELAY_MS / DELAY_STEP_MS);
    localparam logic [18:0] RST_FAIL_STEPS = 19'(FAIL_DELAY_MS / DELAY_STEP_MS);
    localparam logic [18:0] DLY_MAX = 19'(MAX_DELAY_STEPS);
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PHASE_THR = 8'h04;
    localparam logic [7:0] OFS_RES_THR = 8'h08;
    localparam logic [7:0] OFS_RETRIP_DLY = 8'h0C;
    localparam logic [7:0] OFS_FAIL_DLY = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_ELAPSED = 8'h18;
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_RSEL_LSB = 4;
    localparam int unsigned CTRL_RTEN_BIT = 6;
    localparam int unsigned CTRL_LN_LSB = 8;
    localparam int unsigned STAT_COND_LSB = 0;
    localparam int unsigned STAT_BEH_LSB = 4;
    localparam int unsigned STAT_CH_LSB = 8;
    localparam int unsigned STAT_PICK_BIT = 12;
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [1:0] RST_RSEL = 2'h0;
    localparam logic RST_RTEN = 1'b1;
    localparam logic [2:0] RST_LN = 3'h1;
    localparam logic [11:0] RST_PHASE_THR = 12'h014;
    localparam logic [15:0] RST_RES_THR = 16'h04B0;
    localparam logic [23:0] HYST_NUM = 24'h000061;
    localparam logic [23:0] HYST_DEN = 24'h000064;
    localparam logic [16:0] PHASE_SCALE = 17'h0000A;
    typedef enum logic [1:0] {ST_NORMAL = 2'b00, ST_START = 2'b01, ST_BLOCKED = 2'b10} bfp_state_t;
    typedef enum logic [3:0] {
        MODE_CUR = 4'h0, MODE_RELAY = 4'h1, MODE_SIG = 4'h2, MODE_CUR_AND_RELAY = 4'h3,
        MODE_CUR_OR_RELAY = 4'h4, MODE_CUR_OR_SIG = 4'h5, MODE_CUR_OR_SIG_RELAY = 4'h6,
        MODE_SIG_OR_RELAY = 4'h8, MODE_ANY = 4'h9, MODE_ALL = 4'hA
    } bfp_mode_t;
    localparam logic [1:0] RSEL_OFF = 2'h0;
    localparam logic [1:0] RSEL_ONE = 2'h1;
    localparam logic [1:0] RSEL_TWO = 2'h2;
    localparam logic [1:0] RSEL_CALC = 2'h3;
    localparam logic [2:0] COND_NORMAL = 3'h0;
    localparam logic [2:0] COND_START = 3'h1;
    localparam logic [2:0] COND_RETRIP = 3'h2;
    localparam logic [2:0] COND_FAIL = 3'h3;
    localparam logic [2:0] COND_BLOCKED = 3'h4;
    localparam logic [2:0] LN_ON = 3'h1;
    localparam logic [2:0] LN_BLOCKED = 3'h2;
    localparam logic [2:0] LN_TEST = 3'h3;
    localparam logic [2:0] LN_TEST_BLOCKED = 3'h4;
    localparam logic [2:0] LN_OFF = 3'h5;
endpackage

// [test/bfp_breaker_model.sv]
// behavioural model of the breaker trip coils and upstream incomer
`timescale 1ns/1ps
module bfp_breaker_model #(
    parameter int OPEN_DELAY = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic retrip,
    input wire logic breaker_failure_output,
    output logic coil_energised,
    output logic incomer_open
);
    int cnt_r;
    ////////////////////////////////////////////////////////////////////////
    // redundant coil simply follows the retrip contact
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) coil_energised <= 1'b0;
        else coil_energised <= retrip;
    end
    // incomer is slow: mechanism time modelled by a count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cnt_r <= 0;
        else if (!breaker_failure_output) cnt_r <= 0;
        else if (cnt_r < OPEN_DELAY) cnt_r <= cnt_r + 1;
    end
    assign incomer_open = (cnt_r == OPEN_DELAY);
endmodule

// [test/breaker_failure_pickup_timer_tb_top.sv]
// self-checking bench of the breaker failure pick-up timer
`timescale 1ns/1ps
module breaker_failure_pickup_timer_tb_top;
    import bfp_pkg::*;
    localparam int TC = 4;
    logic hclk, hresetn, hsel, hwrite, hready, hresp, meas_valid, sig, rly, blk;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic start, retrip, bfo, blocked, bev, coil, incomer;
    logic [3:0] ftype;
    logic [15:0] ib, i1, ea, eb, ec, en, ia;
    logic ce;
    int failures = 0;
    int n_compared = 0;
    bfp_core #(.TICK_CYCLES(TC), .MEAS_W(16)) bfp_core_i (.hclk(hclk), .hresetn(hresetn),
        .clk_en(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .meas_valid(meas_valid), .phase_a_rms(ia), .phase_b_rms(ib),
        .phase_c_rms(16'h0000), .residual_input_one(i1), .residual_input_two(16'h0000),
        .derived_residual_current(16'h0000), .binary_signal(sig), .relay_state(rly),
        .block_request(blk), .start(start), .retrip(retrip), .breaker_failure_output(bfo),
        .blocked(blocked), .block_event(bev), .event_fault_type(ftype), .event_cur_a(ea),
        .event_cur_b(eb), .event_cur_c(ec), .event_cur_n(en));
    bfp_breaker_model #(.OPEN_DELAY(3)) bfp_breaker_model_i (.hclk(hclk), .hresetn(hresetn),
        .retrip(retrip), .breaker_failure_output(bfo), .coil_energised(coil),
        .incomer_open(incomer));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic setm(input logic [15:0] b, input logic [15:0] n);
        @(posedge hclk);
        ib <= b;
        i1 <= n;
        meas_valid <= 1'b1;
        @(posedge hclk);
        meas_valid <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [7:0] a [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
        logic [31:0] e [7] = '{32'h140, 32'h14, 32'h4B0, 32'h14, 32'h28, 32'h10, 32'h0};
        for (int i = 0; i < 7; i++) begin
            ahb(1'b0, a[i], 32'h0);
            chk("reset_reg", rd, e[i]);
        end
        ahb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
        ahb(1'b0, OFS_STATUS, 32'h0);
        chk("status_ro", rd, 32'h10);
        $display("test regs done");
    endtask
    task automatic t_time;
        int n = 0;
        ahb(1'b1, OFS_RETRIP_DLY, 32'h2);
        ahb(1'b1, OFS_FAIL_DLY, 32'h5);
        @(posedge hclk);
        ib <= 16'h00C9;
        meas_valid <= 1'b1;
        @(posedge hclk);
        meas_valid <= 1'b0;
        do @(posedge hclk); while (start !== 1'b1 && ++n < 50);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (retrip !== 1'b1 && n < 100);
        chk("retrip_time", n, 2 * TC);
        do begin
            @(posedge hclk);
            n++;
        end while (bfo !== 1'b1 && n < 100);
        chk("fail_time", n, 5 * TC);
        repeat (5) @(posedge hclk);
        chk("held", {retrip, coil, incomer}, 3'h7);
        setm(16'h00C3, 16'h0000);
        chk("hyst_hold", start, 1'b1);
        setm(16'h00C1, 16'h0000);
        chk("release", {start, retrip, bfo}, 3'h0);
        $display("test timing done");
    endtask
    task automatic t_block;
        int k = 0;
        blk <= 1'b1;
        setm(16'h00C9, 16'h0000);
        chk("blk_at_pick", {start, blocked}, 2'h1);
        blk <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("unblock", start, 1'b1);
        blk <= 1'b1;
        repeat (4) begin
            @(posedge hclk);
            k += int'(bev);
        end
        chk("blk_start", {start, blocked, 4'(k)}, 6'h11);
        chk("evt", {ftype, eb}, {4'h2, 16'h00C9});
        ahb(1'b0, OFS_STATUS, 32'h0);
        chk("cond_blk", rd[2:0], COND_BLOCKED);
        blk <= 1'b0;
        setm(16'h0000, 16'h0000);
        $display("test block done");
    endtask
    task automatic t_modes;
        logic [3:0] m [4] = '{4'h1, 4'h2, 4'h7, 4'hB};
        logic e [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        rly <= 1'b1;
        sig <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, OFS_CTRL, {28'h0000010, m[i]});
            repeat (24) @(posedge hclk);
            chk("mode", {start, bfo, retrip}, {e[i], e[i], 1'b0});
        end
        ahb(1'b1, OFS_CTRL, 32'h150);
        rly <= 1'b0;
        sig <= 1'b0;
        setm(16'h0000, 16'h04B1);
        chk("res_one", start, 1'b1);
        $display("test modes done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // generous bound: the tests need well under 2000 cycles
    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        complete_run;
    end
    initial begin
        {hresetn, hsel, hwrite, meas_valid, sig, rly, blk} = 7'h00;
        {haddr, hwdata, htrans, ib, i1, ia} = '0;
        ce = 1'b1;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_time;
        t_block;
        t_modes;
        complete_run;
    end
endmodule
